/* inc/tcpp_defines.vh */
// constants for the temperature channel post-processing block
// Function
// - measure internal channel plus up to three external channels, all sharing one rate setting
// - dynamic averaging lengthens every external conversion according to conversion rate
// - dynamic factor 8x at 1/s, 4x at 2/s, 2x at 4/s, 1x at 8/s
// - with dynamic averaging off, external factor stays 1x at every rate
// - first external channel has a four-times digital averaging filter
// - each measurement the filter reports mean of four latest samples
// - averaging_off_bit bypasses the filter and reports raw samples
// - every channel is checked for open and short diode faults
// - a faulted channel reports high byte 80h
// - a diode fault also sets the diode fault status flag
// - external channel one and two connection fixed once at power-up from strap
// - third external channel measured only with channel two anti-parallel pair
// - external beta chosen automatically from detected diode type, except channel one with strap floating
// - strap low, floating pick channel one with, without correction; high picks two
// - second configuration register holds conversion rate for all channels
`ifndef TCPP_DEFINES_VH
`define TCPP_DEFINES_VH
// ====================
// register offsets
`define TCPP_ADDR_CFG2 8'h21
`define TCPP_ADDR_STAT 8'h23
`define TCPP_ADDR_FAULT 8'h26
`define TCPP_ADDR_IEN 8'h28
`define TCPP_ADDR_ICLR 8'h29
`define TCPP_ADDR_TEMP0 8'h00
// ====================
// fields of second configuration register
`define TCPP_CFG2_RATE_LSB 0
`define TCPP_CFG2_DYN 2
`define TCPP_CFG2_AVGOFF 3
`define TCPP_CFG2_RST 8'h00
// ====================
// strap decode and constants
`define TCPP_STRAP_LOW 2'h0
`define TCPP_STRAP_HIGH 2'h1
`define TCPP_STRAP_OPEN 2'h2
`define TCPP_FAULT_HI 8'h80
`define TCPP_CONV_TIME_US 1000
`define TCPP_CLK_MHZ 20
`endif

/* rtl/tcpp_sync.v */
// three-stage input synchroniser with agreement check
`timescale 1ns/10ps
`default_nettype none
module tcpp_sync #(
  parameter W = 1
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // data
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;
  always @(posedge clk) begin
    if (!rst_n) begin
      s1_reg <= {W{1'b0}};
      s2_reg <= {W{1'b0}};
      s3_reg <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // change counts only once stages two and three agree
      if (s2_reg == s3_reg)
        q <= s3_reg;
    end
  end
endmodule // tcpp_sync
`default_nettype wire

/* rtl/tcpp_avg4.v */
// four-sample running average filter for the first external channel
`timescale 1ns/10ps
`default_nettype none
module tcpp_avg4 (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // sample in
  input wire in_valid,
  input wire [10:0] in_data,
  input wire bypass,
  // filtered out
  output reg out_valid,
  output reg [10:0] out_data
);
  reg [10:0] hist_reg [0:3];
  reg [1:0] ptr_reg;
  reg seeded_reg;
  reg [12:0] sum;
  integer i;
  integer j;
  always @* begin
    sum = {2'h0, in_data};
    for (i = 1; i < 4; i = i + 1)
      sum = sum + {2'h0, hist_reg[(ptr_reg + i[1:0]) & 2'h3]};
  end
  always @(posedge clk) begin
    if (!rst_n) begin
      for (j = 0; j < 4; j = j + 1)
        hist_reg[j] <= 11'h000;
      ptr_reg <= 2'h0;
      seeded_reg <= 1'b0;
      out_valid <= 1'b0;
      out_data <= 11'h000;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        if (!seeded_reg) begin
          // avoids early readings biased toward zero
          for (j = 0; j < 4; j = j + 1)
            hist_reg[j] <= in_data;
          seeded_reg <= 1'b1;
          out_data <= in_data;
        end else begin
          hist_reg[ptr_reg] <= in_data;
          ptr_reg <= ptr_reg + 2'h1;
          if (bypass)
            out_data <= in_data;
          else
            out_data <= sum[12:2];
        end
      end
    end
  end
endmodule // tcpp_avg4
`default_nettype wire

/* rtl/tcpp_top.v */
// temperature channel post-processing: scheduling, filter, faults, registers
`timescale 1ns/10ps
`default_nettype none
`include "tcpp_defines.vh"
module tcpp_top #(
  parameter CONV_CYCLES = `TCPP_CONV_TIME_US * `TCPP_CLK_MHZ
) (
  // clock and reset
  input wire SYS_CLK,
  input wire RST_N,
  // strap: low, high and floating seen as two pin samples
  input wire STRAP_HIGH_IN,
  input wire STRAP_LOW_IN,
  // analog front end results
  input wire ADC_VALID,
  input wire [10:0] ADC_DATA,
  input wire ADC_OPEN,
  input wire ADC_SHORT,
  // conversion request to front end
  output reg ADC_START,
  output reg [1:0] ADC_CHAN,
  output reg [3:0] ADC_AVG,
  output reg ADC_BETA_AUTO,
  output reg ADC_CORR_EN,
  output reg ADC_ANTIPAR,
  // register port
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output reg [7:0] REG_RDATA,
  // interrupt
  output wire IRQ
);
  // ====================
  // strap capture
  wire [1:0] strap_sync;
  reg [1:0] strap_reg;
  reg strap_done_reg;
  reg [2:0] settle_reg;
  tcpp_sync #(.W(2)) u_sync (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .d({STRAP_HIGH_IN, STRAP_LOW_IN}),
    .q(strap_sync)
  );
  // strap caught once after sync settles, never re-read
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      strap_reg <= `TCPP_STRAP_OPEN;
      strap_done_reg <= 1'b0;
      settle_reg <= 3'h0;
    end else if (!strap_done_reg) begin
      settle_reg <= settle_reg + 3'h1;
      // sync output only good after four edges, so read on the fifth
      if (settle_reg == 3'h4) begin
        strap_done_reg <= 1'b1;
        if (strap_sync[1])
          strap_reg <= `TCPP_STRAP_HIGH;
        else if (strap_sync[0])
          strap_reg <= `TCPP_STRAP_LOW;
        else
          strap_reg <= `TCPP_STRAP_OPEN;
      end
    end
  end
  // channel one and two connection fixed from strap
  wire ch1_corr = (strap_reg != `TCPP_STRAP_OPEN);
  wire ch2_antipar = (strap_reg == `TCPP_STRAP_HIGH);
  // ====================
  // configuration
  reg [7:0] cfg2_reg;
  reg [3:0] ien_reg;
  wire [1:0] rate = cfg2_reg[`TCPP_CFG2_RATE_LSB +: 2];
  wire dyn_en = cfg2_reg[`TCPP_CFG2_DYN];
  wire averaging_off_bit = cfg2_reg[`TCPP_CFG2_AVGOFF];
  // rate 0..3 means 1,2,4,8 per second
  function [3:0] tcpp_factor;
    input dyn;
    input [1:0] r;
    begin
      if (!dyn)
        tcpp_factor = 4'h1;
      else
        case (r)
          2'h0: tcpp_factor = 4'h8;
          2'h1: tcpp_factor = 4'h4;
          2'h2: tcpp_factor = 4'h2;
          default: tcpp_factor = 4'h1;
        endcase
    end
  endfunction
  // ====================
  // conversion scheduler
  localparam S_IDLE = 2'h0;
  localparam S_CONV = 2'h1;
  localparam S_WAIT = 2'h2;
  reg [1:0] state_reg;
  reg [1:0] chan_reg;
  reg [31:0] gap_reg;
  // round timeout is eight conversion times shifted right by rate; counted in clock cycles
  wire [31:0] period = (CONV_CYCLES * 8) >> rate;
  wire [1:0] last_chan = ch2_antipar ? 2'h3 : 2'h2;
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      state_reg <= S_IDLE;
      chan_reg <= 2'h0;
      gap_reg <= 32'h0;
      ADC_START <= 1'b0;
      ADC_CHAN <= 2'h0;
      ADC_AVG <= 4'h1;
      ADC_BETA_AUTO <= 1'b0;
      ADC_CORR_EN <= 1'b0;
      ADC_ANTIPAR <= 1'b0;
    end else begin
      ADC_START <= 1'b0;
      if (state_reg != S_IDLE)
        gap_reg <= gap_reg + 32'h1;
      case (state_reg)
        S_IDLE: begin
          if (strap_done_reg) begin
            state_reg <= S_CONV;
            chan_reg <= 2'h0;
            gap_reg <= 32'h0;
          end
        end
        S_CONV: begin
          ADC_START <= 1'b1;
          ADC_CHAN <= chan_reg;
          // internal channel keeps unity factor
          ADC_AVG <= (chan_reg == 2'h0) ? 4'h1 :
                     tcpp_factor(dyn_en, rate);
          // front end detects diode type and picks beta itself
          ADC_BETA_AUTO <= (chan_reg == 2'h1) ? ch1_corr :
                           (chan_reg != 2'h0);
          ADC_CORR_EN <= (chan_reg == 2'h1) ? ch1_corr : 1'b1;
          ADC_ANTIPAR <= ch2_antipar && (chan_reg >= 2'h2);
          state_reg <= S_WAIT;
        end
        S_WAIT: begin
          if (ADC_VALID) begin
            if (chan_reg != last_chan) begin
              chan_reg <= chan_reg + 2'h1;
              state_reg <= S_CONV;
            end else begin
              chan_reg <= 2'h0;
              state_reg <= S_IDLE;
            end
          end else if (gap_reg >= period) begin
            // lost result: restart the round rather than hang
            chan_reg <= 2'h0;
            state_reg <= S_CONV;
            gap_reg <= 32'h0;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
  // ====================
  // filter and result store
  wire avg_valid;
  wire [10:0] avg_data;
  wire ch1_sample = ADC_VALID && (state_reg == S_WAIT) &&
                    (chan_reg == 2'h1) && !ADC_OPEN && !ADC_SHORT;
  tcpp_avg4 u_avg (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .in_valid(ch1_sample),
    .in_data(ADC_DATA),
    .bypass(averaging_off_bit),
    .out_valid(avg_valid),
    .out_data(avg_data)
  );
  reg [15:0] temp_reg [0:3];
  reg [3:0] fault_reg;
  reg [3:0] stat_reg;
  wire take = ADC_VALID && (state_reg == S_WAIT);
  wire bad = ADC_OPEN || ADC_SHORT;
  wire [3:0] fault_set = take && bad ? (4'h1 << chan_reg) : 4'h0;
  wire clr_stb = REG_WR && (REG_ADDR == `TCPP_ADDR_ICLR);
  integer k;
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      for (k = 0; k < 4; k = k + 1)
        temp_reg[k] <= 16'h0000;
      fault_reg <= 4'h0;
      stat_reg <= 4'h0;
      cfg2_reg <= `TCPP_CFG2_RST;
      ien_reg <= 4'h0;
    end else begin
      if (take) begin
        if (bad) begin
          temp_reg[chan_reg] <= {`TCPP_FAULT_HI, 8'h00};
        end else if (chan_reg != 2'h1) begin
          temp_reg[chan_reg] <= {ADC_DATA, 5'h00};
        end
        fault_reg[chan_reg] <= bad;
      end
      if (avg_valid)
        temp_reg[1] <= {avg_data, 5'h00};
      // set wins over a clear in the same cycle
      stat_reg <= (stat_reg & ~(clr_stb ? REG_WDATA[3:0] : 4'h0))
                  | fault_set;
      if (REG_WR && REG_ADDR == `TCPP_ADDR_CFG2)
        cfg2_reg <= {4'h0, REG_WDATA[3:0]};
      if (REG_WR && REG_ADDR == `TCPP_ADDR_IEN)
        ien_reg <= REG_WDATA[3:0];
    end
  end
  assign IRQ = |(stat_reg & ien_reg);
  // ====================
  // register read
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      if (REG_ADDR < 8'h08) begin
        if (REG_ADDR[0])
          REG_RDATA <= temp_reg[REG_ADDR[2:1]][7:0];
        else
          REG_RDATA <= temp_reg[REG_ADDR[2:1]][15:8];
      end else begin
        case (REG_ADDR)
          `TCPP_ADDR_CFG2: REG_RDATA <= cfg2_reg;
          `TCPP_ADDR_STAT: REG_RDATA <= {4'h0, stat_reg};
          `TCPP_ADDR_FAULT: REG_RDATA <= {4'h0, fault_reg};
          `TCPP_ADDR_IEN: REG_RDATA <= {4'h0, ien_reg};
          default: REG_RDATA <= 8'h00;
        endcase
      end
    end else begin
      REG_RDATA <= 8'h00;
    end
  end
endmodule // tcpp_top
`default_nettype wire

/* test/tcpp_top_chk.sv */
// assertion checker for the temperature post-processing top
`timescale 1ns/10ps
`default_nettype none
module tcpp_chk (
  // ====================
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // strap and front end
  input wire logic STRAP_HIGH_IN,
  input wire logic STRAP_LOW_IN,
  input wire logic ADC_VALID,
  input wire logic ADC_START,
  input wire logic [1:0] ADC_CHAN,
  input wire logic [3:0] ADC_AVG,
  input wire logic ADC_CORR_EN,
  input wire logic ADC_ANTIPAR,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // shadow of the rate register, written on the same edge as the design's copy
  reg [7:0] cfg_reg;
  always @(posedge SYS_CLK) begin
    if (!RST_N) cfg_reg <= 8'h00;
    else if (REG_WR && REG_ADDR == 8'h21) cfg_reg <= REG_WDATA;
  end
  start_pulse_a: assert property (ADC_START |=> !ADC_START)
    else $error("start held too long");
  rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
    else $error("read data outside read slot");
  req_hold_a: assert property (!ADC_START |-> $stable({ADC_CHAN, ADC_AVG}))
    else $error("request fields moved");
  chan3_gate_a: assert property (ADC_START && ADC_CHAN == 2'h3 |-> ADC_ANTIPAR)
    else $error("third channel without pair");
  strap_corr_a: assert property (ADC_START && ADC_CHAN == 2'h1 && STRAP_LOW_IN
    && !STRAP_HIGH_IN |-> ADC_CORR_EN) else $error("correction off");
  round_cont_a: assert property (ADC_VALID |-> ##[1:8] ADC_START)
    else $error("round stalled");
  dyn_off_a: assert property (ADC_START && ADC_CHAN != 2'h0
    && !$past(cfg_reg[2]) |-> ADC_AVG == 4'h1) else $error("factor not unity");
  dyn_on_a: assert property (ADC_START && ADC_CHAN != 2'h0 && $past(cfg_reg[2])
    |-> ADC_AVG == (4'h8 >> $past(cfg_reg[1:0]))) else $error("factor wrong");
  cover property (ADC_START && ADC_CHAN == 2'h3);
  cover property (REG_RD ##1 REG_RDATA != 8'h00);
  cover property (ADC_START && ADC_AVG == 4'h8);
endmodule // tcpp_chk
bind tcpp_top tcpp_chk u_chk (.SYS_CLK, .RST_N, .STRAP_HIGH_IN, .STRAP_LOW_IN,
  .ADC_VALID, .ADC_START, .ADC_CHAN, .ADC_AVG, .ADC_CORR_EN, .ADC_ANTIPAR,
  .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA);
`default_nettype wire

/* test/tcpp_fe_model.sv */
// behavioural front end answering conversion requests
`timescale 1ns/10ps
`default_nettype none
module tcpp_fe_model (
  // ====================
  // clock, reset, request
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [1:0] chan,
  input wire logic antipar,
  // scenario controls
  input wire logic [3:0][10:0] val,
  input wire logic [3:0] opn,
  input wire logic [3:0] shr,
  input wire logic [7:0] lat,
  // result
  output logic valid = 1'b0,
  output logic [10:0] data = 11'h000,
  output logic open_flt = 1'b0,
  output logic short_flt = 1'b0
);
  int cnt_reg = 0;
  logic [1:0] ch_reg = 2'h0;
  always @(posedge clk) begin
    valid <= 1'b0;
    // idle lines toggle so stale values never look good
    data <= ~data;
    open_flt <= ~open_flt;
    short_flt <= ~short_flt;
    if (!rst_n) cnt_reg <= 0;
    else if (start) begin
      cnt_reg <= lat;
      ch_reg <= chan;
    end else if (cnt_reg == 1) begin
      valid <= 1'b1;
      data <= val[ch_reg];
      // unpaired third diode reads as open
      open_flt <= opn[ch_reg] | (ch_reg == 2'h3 && !antipar);
      short_flt <= shr[ch_reg];
      cnt_reg <= 0;
    end else if (cnt_reg > 1) cnt_reg <= cnt_reg - 1;
  end
endmodule // tcpp_fe_model
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench for the temperature post-processing top
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // ====================
  // signals
  logic clk = 1'b0, rst_n = 1'b0, st_hi = 1'b0, st_lo = 1'b1;
  logic vld, opf, shf, start, beta, corr, apar, irq, wr = 1'b0, rd = 1'b0;
  logic [10:0] dat;
  logic [3:0][10:0] val = {11'h0c7, 11'h2a5, 11'h100, 11'h321};
  logic [1:0] chan;
  logic [3:0] avg, opn = 4'h0, shr = 4'h0;
  logic [7:0] addr = 8'h00, wdat = 8'h00, rdat, d, lat = 8'h04;
  int error_cnt = 0, checks = 0, cyc = 0;
  tcpp_top #(.CONV_CYCLES(50)) DUT (.SYS_CLK(clk), .RST_N(rst_n),
    .STRAP_HIGH_IN(st_hi), .STRAP_LOW_IN(st_lo), .ADC_VALID(vld),
    .ADC_DATA(dat), .ADC_OPEN(opf), .ADC_SHORT(shf), .ADC_START(start),
    .ADC_CHAN(chan), .ADC_AVG(avg), .ADC_BETA_AUTO(beta), .ADC_CORR_EN(corr),
    .ADC_ANTIPAR(apar), .REG_ADDR(addr), .REG_WDATA(wdat), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdat), .IRQ(irq));
  tcpp_fe_model fe (.clk(clk), .rst_n(rst_n), .start(start), .chan(chan),
    .antipar(apar), .val(val), .opn(opn), .shr(shr), .lat(lat), .valid(vld),
    .data(dat), .open_flt(opf), .short_flt(shf));
  initial forever #25 clk = ~clk;
  // hang guard, generous for a few dozen rounds
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      wrap_up;
    end
  end
  // ====================
  // shared tasks
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rst_dut(input logic h, input logic l);
    st_hi <= h;
    st_lo <= l;
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdat <= v;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 d = rdat;
  endtask
  task automatic rdt(input logic [1:0] c, input logic [10:0] e);
    logic [7:0] h;
    bus(1'b0, {5'h0, c, 1'b0}, 8'h00);
    h = d;
    bus(1'b0, {5'h0, c, 1'b1}, 8'h00);
    chk("temp", {e, 5'h00}, {h, d});
  endtask
  task automatic wait_ch(input logic [1:0] c);
    do @(posedge clk); while (!(vld && chan == c));
    repeat (3) @(posedge clk);
  endtask
  task automatic wait_start(input logic [1:0] c);
    do @(posedge clk); while (!(start && chan == c));
    #1;
  endtask
  // ====================
  // scenarios
  task automatic t_filter;
    wait_ch(1);
    rdt(1, 11'h100);
    val[1] <= 11'h200;
    wait_ch(1);
    rdt(1, 11'h140);
    wait_ch(1);
    rdt(1, 11'h180);
    rdt(0, 11'h321);
    rdt(2, 11'h2a5);
    rdt(3, 11'h000);
    // value must be in place before the model latches the next sample
    val[1] <= 11'h055;
    bus(1'b1, 8'h21, 8'h08);
    wait_ch(1);
    wait_ch(1);
    rdt(1, 11'h055);
    $display("filter test done");
  endtask
  task automatic t_fault;
    opn[2] <= 1'b1;
    wait_ch(2);
    bus(1'b0, 8'h04, 8'h00);
    chk("fault high", 8'h80, d);
    bus(1'b0, 8'h23, 8'h00);
    chk("status", 8'h04, d);
    chk("irq masked", 1'b0, irq);
    bus(1'b1, 8'h28, 8'h04);
    chk("irq", 1'b1, irq);
    opn[2] <= 1'b0;
    shr[0] <= 1'b1;
    wait_ch(0);
    wait_ch(2);
    bus(1'b0, 8'h26, 8'h00);
    chk("live fault", 8'h01, d);
    shr[0] <= 1'b0;
    wait_ch(0);
    bus(1'b1, 8'h29, 8'h05);
    bus(1'b0, 8'h23, 8'h00);
    chk("cleared", 8'h00, d);
    chk("irq off", 1'b0, irq);
    bus(1'b0, 8'h7e, 8'h00);
    chk("unmapped", 8'h00, d);
    $display("fault test done");
  endtask
  task automatic t_dyn;
    // three channels must fit inside the rate-3 round timeout
    lat <= 8'h0a;
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, 8'h21, 8'h04 | r[7:0]);
      wait_start(2'h1);
      wait_start(2'h2);
      chk("dyn factor", 4'h8 >> r, avg);
    end
    bus(1'b1, 8'h21, 8'h00);
    wait_start(2'h1);
    wait_start(2'h2);
    chk("plain factor", 4'h1, avg);
    lat <= 8'h04;
    $display("dynamic test done");
  endtask
  task automatic t_strap(input logic h, l, input logic [1:0] c, input logic e);
    rst_dut(h, l);
    wait_start(c);
    chk("correction", {e, e}, {corr, beta});
    if (h) begin
      wait_ch(3);
      rdt(3, 11'h0c7);
    end
    $display("strap test done");
  endtask
  initial begin
    rst_dut(1'b0, 1'b1);
    t_filter;
    t_fault;
    t_dyn;
    t_strap(1'b0, 1'b0, 2'h1, 1'b0);
    t_strap(1'b1, 1'b0, 2'h2, 1'b1);
    t_strap(1'b0, 1'b1, 2'h1, 1'b1);
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire
